// [dv/slc_properties.sv]
// slc_properties: concurrent checks on the register and lane signals between
// the programming end and the configuration bank.
// assumes one clock, rst asynchronous active high, instantiated beside link_a.
`timescale 1ns/1ps
module slc_properties
  import slc_pkg::*;
#(
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  // lane side
  input wire logic lane_valid,
  input wire logic sysref,
  input wire logic ilas_valid,
  input wire logic ilas_link,
  input wire logic [7:0] ilas_did,
  input wire logic [7:0] ilas_bid,
  input wire logic [7:0] ilas_lid,
  input wire logic [4:0] ilas_lane_m1
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic page_q, power_q, sub_q, arm_q, done0_q;
  logic [7:0] id_q [2][4];
  logic [4:0] lanes_q [2];
  wire arm_wr = cfg_wr && cfg_addr == SYNC_CTRL_OFS && cfg_wdata == SYNC_ARM;

  // shadow of what the programming end has written, per page
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {page_q, power_q, sub_q, arm_q, done0_q} <= 5'h00;
      id_q <= '{default: 8'h00};
      lanes_q <= '{default: 5'h00};
    end else if (cfg_wr) begin
      if (cfg_addr == LINK_POWER_CTRL_OFS) power_q <= cfg_wdata == LINK_POWER_UP;
      if (cfg_addr == LINK_MODE_CTRL_OFS) begin
        page_q <= cfg_wdata[LINK_PAGE_SELECT_BIT] & cfg_wdata[TWO_LINK_ENABLE_BIT];
      end
      if (cfg_addr == SUBCLASS_TOTAL_BITS_OFS) sub_q <= 1'b1;
      if (arm_wr) arm_q <= 1'b1;
      if (cfg_addr == LANE_ENABLE_MASK_OFS && !page_q) done0_q <= 1'b1;
      if (cfg_addr >= EXPECTED_DEVICE_IDENT_OFS && cfg_addr <= EXPECTED_LANE_IDENT_OFS) begin
        id_q[page_q][cfg_addr[1:0]] <= cfg_wdata;
      end
      if (cfg_addr == SCRAMBLE_LANE_COUNT_OFS) lanes_q[page_q] <= cfg_wdata[4:0];
    end
  end

  rd_answer_a: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read strobe without answer");
  rvalid_pulse_a: assert property (!cfg_rd |=> !cfg_rvalid)
    else $error("answer without read strobe");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  power_first_a: assert property (cfg_wr && cfg_addr >= LINK_MODE_CTRL_OFS |-> power_q)
    else $error("link range written before power up");
  lane_count_a: assert property (
    cfg_wr && cfg_addr == SCRAMBLE_LANE_COUNT_OFS |-> cfg_wdata[4:0] == 5'(LANES - 1))
    else $error("lane count not stored minus one");
  page_order_a: assert property (
    cfg_wr && cfg_addr == LINK_MODE_CTRL_OFS && cfg_wdata[LINK_PAGE_SELECT_BIT] |-> done0_q)
    else $error("page one before page zero complete");
  arm_order_a: assert property (arm_wr |-> sub_q && $past(cfg_wr) &&
    $past(cfg_addr) == SYNC_CTRL_OFS && $past(cfg_wdata) == SYNC_MODE_ONESHOT)
    else $error("sync armed out of order");
  sysref_after_a: assert property (arm_wr |-> ##[1:8] sysref)
    else $error("no sysref after arming");
  ident_match_a: assert property (ilas_valid |-> ilas_did == id_q[ilas_link][0] &&
    ilas_bid == id_q[ilas_link][1] && ilas_lid == id_q[ilas_link][2] &&
    ilas_lane_m1 == lanes_q[ilas_link])
    else $error("link config differs from programmed ids");
  data_late_a: assert property (lane_valid |-> arm_q && power_q)
    else $error("lane data before sync armed");
endmodule

// [dv/test_serdes_link_config_regs.sv]
// test_serdes_link_config_regs: host and bank face each other on link_a; a
// second bank on link_f is driven by bench tasks, also with broken ids.
// assumes the slc package and interface are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module test_serdes_link_config_regs;
  import slc_pkg::*;
  localparam logic [7:0] DID = 8'h5a;
  localparam logic [7:0] BID = 8'h03;
  localparam logic [7:0] LID = 8'h02;
  localparam logic [7:0] INTERP = 8'h04;
  localparam logic [63:0] PAT = 64'h0123456789abcdef;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic tx_valid = 1'b0;
  logic [63:0] tx_octet = 64'h0, sample_a, sample_f;
  logic busy, ready, valid_a, valid_f, run_a, run_f, fmt_a, powered_f;
  logic [7:0] rate_a;
  logic [2:0] sub_a;
  logic [4:0] lanes_a;
  logic [1:0] ok_a, ok_f;
  logic [11:0] regs [18] = '{12'h110, 12'h112, 12'h201, 12'h450, 12'h451, 12'h452, 12'h453,
    12'h454, 12'h455, 12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h45d, 12'h46c,
    12'h476, 12'h47d};
  int error_cnt = 0;
  int checks = 0;
  always #2.5 clock = ~clock;
  slc_link_if #(.NUM_LANES(8)) link_a ();
  slc_link_if #(.NUM_LANES(8)) link_f ();
  slc_cfg_host #(.TWO_LINKS(1'b1), .DEV_ID(DID), .BANK_ID(BID), .LANE_ID(LID),
    .UNSIGNED_DATA(1'b1), .INTERP(INTERP)) slc_cfg_host_i (.clock(clock), .rst(rst),
    .link(link_a.host), .start(start), .tx_octet(tx_octet), .tx_valid(tx_valid),
    .busy(busy), .ready(ready));
  slc_cfg_dev slc_cfg_dev_i (.clock(clock), .rst(rst), .link(link_a.dev),
    .filter_rate_select(rate_a), .sample_number_format(fmt_a), .subclass(sub_a),
    .scramble_en(), .lane_count_m1(lanes_a), .link_powered(), .link_running(run_a),
    .ident_ok(ok_a), .sample_out(sample_a), .sample_valid(valid_a));
  slc_cfg_dev slc_cfg_dev_f_i (.clock(clock), .rst(rst), .link(link_f.dev),
    .filter_rate_select(), .sample_number_format(), .subclass(), .scramble_en(),
    .lane_count_m1(), .link_powered(powered_f), .link_running(run_f), .ident_ok(ok_f),
    .sample_out(sample_f), .sample_valid(valid_f));
  slc_properties #(.LANES(8)) slc_properties_i (.clock(clock), .rst(rst),
    .cfg_addr(link_a.cfg_addr), .cfg_wdata(link_a.cfg_wdata), .cfg_wr(link_a.cfg_wr),
    .cfg_rd(link_a.cfg_rd), .cfg_rdata(link_a.cfg_rdata), .cfg_rvalid(link_a.cfg_rvalid),
    .lane_valid(link_a.lane_valid), .sysref(link_a.sysref), .ilas_valid(link_a.ilas_valid),
    .ilas_link(link_a.ilas_link), .ilas_did(link_a.ilas_did), .ilas_bid(link_a.ilas_bid),
    .ilas_lid(link_a.ilas_lid), .ilas_lane_m1(link_a.ilas_lane_m1));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    link_f.cfg_wr <= 1'b1;
    link_f.cfg_addr <= a;
    link_f.cfg_wdata <= d;
    @(posedge clock);
    link_f.cfg_wr <= 1'b0;
    link_f.cfg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    link_f.cfg_rd <= 1'b1;
    link_f.cfg_addr <= a;
    @(posedge clock);
    link_f.cfg_rd <= 1'b0;
    #1;
    `CHK(link_f.cfg_rvalid, 1'b1)
    `CHK(link_f.cfg_rdata, e)
  endtask
  // one-cycle lane-side event; ids are what the far side claims
  task automatic ev(input logic sy, input logic il, input logic mf, input logic [7:0] did,
      input logic [7:0] bid, input logic [7:0] lid, input logic [4:0] lm1);
    @(posedge clock);
    link_f.sysref <= sy;
    link_f.ilas_valid <= il;
    link_f.lane_mf_start <= {8{mf}};
    {link_f.ilas_did, link_f.ilas_bid, link_f.ilas_lid, link_f.ilas_lane_m1} <= {did, bid, lid, lm1};
    @(posedge clock);
    {link_f.sysref, link_f.ilas_valid, link_f.lane_mf_start} <= 10'h000;
    #1;
  endtask

  task automatic test_host();
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    for (int n = 0; n < 400 && ready !== 1'b1; n++) @(posedge clock);
    `CHK(ready, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(rate_a, INTERP)
    `CHK(fmt_a, 1'b1)
    `CHK(lanes_a, 5'h07)
    `CHK(sub_a, 3'h1)
    `CHK(ok_a, 2'b11)
    `CHK(run_a, 1'b1)
    @(posedge clock);
    tx_valid <= 1'b1;
    tx_octet <= PAT;
    @(posedge clock);
    tx_valid <= 1'b0;
    #1;
    `CHK(valid_a, 1'b1)
    `CHK(sample_a, PAT ^ {8{UNSIGNED_FLIP}})
    $display("test_host done");
  endtask
  task automatic test_regs();
    rd(LINK_POWER_CTRL_OFS, LINK_POWER_RST);
    `CHK(powered_f, 1'b0)
    rd(12'h7ff, 8'h00);
    wr(LINK_POWER_CTRL_OFS, LINK_POWER_UP);
    `CHK(powered_f, 1'b1)
    foreach (regs[i]) wr(regs[i], 8'h30 + 8'(i));
    foreach (regs[i]) rd(regs[i], 8'h30 + 8'(i));
    wr(LINK_MODE_CTRL_OFS, 8'h0c);
    wr(EXPECTED_DEVICE_IDENT_OFS, 8'hc3);
    rd(EXPECTED_DEVICE_IDENT_OFS, 8'hc3);
    rd(LANE_POWERDOWN_MASK_OFS, 8'h32);
    wr(LINK_MODE_CTRL_OFS, 8'h08);
    rd(EXPECTED_DEVICE_IDENT_OFS, 8'h33);
    wr(LINK_MODE_CTRL_OFS, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_link();
    wr(SAMPLE_FORMAT_CTRL_OFS, 8'h00);
    wr(LANE_POWERDOWN_MASK_OFS, 8'h00);
    wr(EXPECTED_DEVICE_IDENT_OFS, DID);
    wr(EXPECTED_BANK_IDENT_OFS, BID);
    wr(EXPECTED_LANE_IDENT_OFS, LID);
    wr(SCRAMBLE_LANE_COUNT_OFS, 8'h07);
    wr(SUBCLASS_TOTAL_BITS_OFS, 8'h2f);
    wr(DESKEW_LANE_MASK_OFS, 8'hff);
    wr(LANE_ENABLE_MASK_OFS, 8'h0f);
    wr(SYNC_CTRL_OFS, SYNC_MODE_ONESHOT);
    wr(SYNC_CTRL_OFS, SYNC_ARM);
    ev(1'b1, 1'b0, 1'b0, DID, BID, LID, 5'h07);
    ev(1'b0, 1'b1, 1'b0, DID, BID, LID, 5'h07);
    ev(1'b0, 1'b0, 1'b1, DID, BID, LID, 5'h07);
    `CHK(ok_f, 2'b01)
    `CHK(run_f, 1'b1)
    @(posedge clock);
    link_f.lane_valid <= 1'b1;
    link_f.lane_octet <= PAT;
    @(posedge clock);
    link_f.lane_valid <= 1'b0;
    #1;
    `CHK(valid_f, 1'b1)
    `CHK(sample_f, {32'h0, PAT[31:0]})
    for (int k = 0; k < 4; k++) begin
      ev(1'b0, 1'b1, 1'b0, DID ^ 8'(k == 0), BID ^ 8'(k == 1), LID ^ 8'(k == 2),
        5'h07 ^ 5'(k == 3));
      `CHK(ok_f, 2'b00)
      `CHK(run_f, 1'b0)
      ev(1'b0, 1'b1, 1'b0, DID, BID, LID, 5'h07);
      `CHK(ok_f, 2'b01)
    end
    wr(DESKEW_LANE_MASK_OFS, 8'h00);
    `CHK(run_f, 1'b0)
    $display("test_link done");
  endtask

  initial begin
    {link_f.cfg_addr, link_f.cfg_wdata, link_f.cfg_wr, link_f.cfg_rd} <= 22'h0;
    {link_f.lane_octet, link_f.lane_valid, link_f.lane_mf_start, link_f.sysref} <= 74'h0;
    {link_f.ilas_valid, link_f.ilas_link, link_f.ilas_did, link_f.ilas_bid} <= 18'h0;
    {link_f.ilas_lid, link_f.ilas_lane_m1} <= 13'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    test_host();
    test_regs();
    test_link();
    stop_test();
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    stop_test();
  end
endmodule

// [logic/slc_cfg_dev.sv]
// slc_cfg_dev: configuration bank of the receive side, with the lane mask,
// deskew, id check and sample format logic that the bank steers.
// assumes one clock and a register port driven by cfg_host or software.
//
// Notes on behaviour
// - writable interpolation ratio select field
// - format bit: 0 two's complement, 1 unsigned
// - transport range banked per link, power shared
// - power register all zeros powers interface up
// - expected device id matches transmitter's
// - expected bank id matches transmitter's
// - expected lane id matches transmitter's
// - link sizes stored as value minus one
// - deskew mask picks lanes for alignment
// - cleared enable bit keeps lane data out
// - subclass, then arm one-shot multiframe sync
`timescale 1ns/1ps
module slc_cfg_dev
  import slc_pkg::*;
#(
  parameter int NUM_LANES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link and register port
  slc_link_if.dev link,
  // datapath user side
  output logic [7:0] filter_rate_select,
  output logic sample_number_format,
  output logic [2:0] subclass,
  output logic scramble_en,
  output logic [4:0] lane_count_m1,
  output logic link_powered,
  output logic link_running,
  output logic [1:0] ident_ok,
  output logic [NUM_LANES*8-1:0] sample_out,
  output logic sample_valid
);
  import slc_pkg::*;

  logic [7:0] fmt_q;
  logic [7:0] interp_q;
  logic [7:0] power_q;
  logic [7:0] lane_pd_q;
  logic two_link_q;
  logic page_q;
  logic [7:0] sync_q;
  logic synced_q;
  logic [7:0] bank_q [NUM_LINKS][BANK_REGS];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [1:0] ident_ok_q;
  logic [NUM_LANES-1:0] aligned_q;
  logic [NUM_LANES*8-1:0] sample_q;
  logic sample_valid_q;

  logic wr_page;
  logic [4:0] wr_idx;
  logic [4:0] rd_idx;
  logic arm_wr;
  logic [NUM_LANES-1:0] lane_en;
  logic [NUM_LANES-1:0] deskew_set;
  logic deskew_done;

  // page select only matters once two links are enabled
  assign wr_page = two_link_q & page_q;
  assign wr_idx = slc_bank_index(link.cfg_addr);
  assign rd_idx = slc_bank_index(link.cfg_addr);
  assign arm_wr = link.cfg_wr && link.cfg_addr == SYNC_CTRL_OFS &&
                  link.cfg_wdata[SYNC_ENABLE_BIT];

  // shared registers, written once whatever the page
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fmt_q <= REG_RST;
      interp_q <= REG_RST;
      power_q <= LINK_POWER_RST;
      lane_pd_q <= REG_RST;
      two_link_q <= 1'b0;
      page_q <= 1'b0;
    end else if (link.cfg_wr) begin
      unique case (link.cfg_addr)
        SAMPLE_FORMAT_CTRL_OFS: fmt_q <= link.cfg_wdata;
        INTERPOLATION_SELECT_OFS: interp_q <= link.cfg_wdata;
        LINK_POWER_CTRL_OFS: power_q <= link.cfg_wdata;
        LANE_POWERDOWN_MASK_OFS: lane_pd_q <= link.cfg_wdata;
        LINK_MODE_CTRL_OFS: begin
          two_link_q <= link.cfg_wdata[TWO_LINK_ENABLE_BIT];
          page_q <= link.cfg_wdata[LINK_PAGE_SELECT_BIT];
        end
        default: ;
      endcase
    end
  end

  // banked transport range: one copy per link
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int r = 0; r < BANK_REGS; r++) begin
          bank_q[l][r] <= REG_RST;
        end
      end
    end else if (link.cfg_wr && wr_idx != BK_NONE) begin
      // page taken from the mode value being written so a page change
      // lands in the copy it selects
      if (link.cfg_addr == LINK_MODE_CTRL_OFS) begin
        bank_q[link.cfg_wdata[TWO_LINK_ENABLE_BIT] &
               link.cfg_wdata[LINK_PAGE_SELECT_BIT]][BK_MODE] <= link.cfg_wdata;
      end else begin
        bank_q[wr_page][wr_idx[3:0]] <= link.cfg_wdata;
      end
    end
  end

  // readback of the stored value, from the current page when banked, one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= REG_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= link.cfg_rd;
      if (link.cfg_rd) begin
        if (rd_idx != BK_NONE) begin
          rdata_q <= bank_q[wr_page][rd_idx[3:0]];
        end else begin
          unique case (link.cfg_addr)
            SYNC_CTRL_OFS: rdata_q <= sync_q;
            SAMPLE_FORMAT_CTRL_OFS: rdata_q <= fmt_q;
            INTERPOLATION_SELECT_OFS: rdata_q <= interp_q;
            LINK_POWER_CTRL_OFS: rdata_q <= power_q;
            LANE_POWERDOWN_MASK_OFS: rdata_q <= lane_pd_q;
            default: rdata_q <= REG_RST;
          endcase
        end
      end
    end
  end
  assign link.cfg_rdata = rdata_q;
  assign link.cfg_rvalid = rvalid_q;

  // one-shot sync: enable bit self-clears when sysref lands;
  // a write in the same cycle wins so a re-arm is never lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q <= REG_RST;
      synced_q <= 1'b0;
    end else if (link.cfg_wr && link.cfg_addr == SYNC_CTRL_OFS) begin
      sync_q <= link.cfg_wdata;
      if (arm_wr) begin
        synced_q <= 1'b0;
      end
    end else if (link.sysref && sync_q[SYNC_ENABLE_BIT] && sync_q[SYNC_ONESHOT_BIT]) begin
      sync_q[SYNC_ENABLE_BIT] <= 1'b0;
      synced_q <= 1'b1;
    end
  end

  // lanes carrying data: enabled on any active link, not powered down
  always_comb begin
    lane_en = bank_q[0][BK_LANE_EN][NUM_LANES-1:0];
    if (two_link_q) begin
      lane_en = lane_en | bank_q[1][BK_LANE_EN][NUM_LANES-1:0];
    end
    lane_en = lane_en & ~lane_pd_q[NUM_LANES-1:0];
  end

  always_comb begin
    deskew_set = bank_q[0][BK_DESKEW][NUM_LANES-1:0];
    if (two_link_q) begin
      deskew_set = deskew_set | bank_q[1][BK_DESKEW][NUM_LANES-1:0];
    end
    deskew_set = deskew_set & lane_en;
  end

  // a deskew lane counts as aligned once its multiframe start is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aligned_q <= '0;
    end else begin
      // a start seen in the arming cycle is kept: the set beats the clear
      aligned_q <= (arm_wr ? '0 : aligned_q) | (link.lane_mf_start & deskew_set);
    end
  end
  assign deskew_done = |deskew_set && (aligned_q & deskew_set) == deskew_set;

  // received link configuration checked against the stored copy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ident_ok_q <= 2'b00;
    end else if (link.ilas_valid) begin
      ident_ok_q[link.ilas_link] <=
        link.ilas_did == bank_q[link.ilas_link][BK_DID] &&
        link.ilas_bid == bank_q[link.ilas_link][BK_BID] &&
        link.ilas_lid == bank_q[link.ilas_link][BK_LID] &&
        link.ilas_lane_m1 == bank_q[link.ilas_link][BK_LANES][LANE_COUNT_W-1:0];
    end
  end

  assign link_powered = power_q == LINK_POWER_UP;
  assign link_running = link_powered && synced_q && deskew_done && ident_ok_q[0] &&
                        (!two_link_q || ident_ok_q[1]);

  // samples: unsigned input is flipped to two's complement internally
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_q <= '0;
      sample_valid_q <= 1'b0;
    end else begin
      sample_valid_q <= link.lane_valid && link_running;
      for (int i = 0; i < NUM_LANES; i++) begin
        if (lane_en[i]) begin
          sample_q[i*8 +: 8] <= link.lane_octet[i*8 +: 8] ^
            (fmt_q[SAMPLE_NUMBER_FORMAT_BIT] ? UNSIGNED_FLIP : REG_RST);
        end else begin
          sample_q[i*8 +: 8] <= REG_RST;
        end
      end
    end
  end

  assign filter_rate_select = interp_q;
  assign sample_number_format = fmt_q[SAMPLE_NUMBER_FORMAT_BIT];
  assign subclass = bank_q[0][BK_SUBCLASS][7:SUBCLASS_LSB];
  assign scramble_en = bank_q[0][BK_LANES][SCRAMBLE_BIT];
  assign lane_count_m1 = bank_q[0][BK_LANES][LANE_COUNT_W-1:0];
  assign ident_ok = ident_ok_q;
  assign sample_out = sample_q;
  assign sample_valid = sample_valid_q;
endmodule

// [logic/slc_cfg_host.sv]
// slc_cfg_host: programming sequencer and transmitter end. It writes the
// bank in the required order, arms sync, then sends link config and data.
// assumes the device answers reads one cycle after the strobe.
`timescale 1ns/1ps
module slc_cfg_host
  import slc_pkg::*;
#(
  parameter int NUM_LANES = 8,
  parameter logic TWO_LINKS = 1'b0,
  parameter logic [7:0] DEV_ID = 8'h00,
  parameter logic [7:0] BANK_ID = 8'h00,
  parameter logic [7:0] LANE_ID = 8'h00,
  parameter int LANES = 8,
  parameter int OCTETS = 1,
  parameter int FRAMES = 32,
  parameter int CONVERTERS = 2,
  parameter int RESOLUTION = 16,
  parameter int SAMPLES = 1,
  parameter logic [2:0] SUBCLASS_SEL = 3'h1,
  parameter logic [2:0] REVISION = 3'h1,
  parameter logic UNSIGNED_DATA = 1'b0,
  parameter logic [7:0] INTERP = 8'h00
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link and register port
  slc_link_if.host link,
  // user side
  input wire logic start,
  input wire logic [NUM_LANES*8-1:0] tx_octet,
  input wire logic tx_valid,
  output logic busy,
  output logic ready
);
  import slc_pkg::*;

  typedef enum logic [3:0] {
    SLC_IDLE = 4'b0001,
    SLC_PROG = 4'b0010,
    SLC_ALIGN = 4'b0100,
    SLC_RUN = 4'b1000
  } slc_state_e;

  localparam int PER_LINK = 16;
  localparam int LAST_STEP = 4 + PER_LINK * (TWO_LINKS ? 2 : 1) + 1;

  slc_state_e state_q;
  logic [6:0] step_q;
  logic [1:0] align_q;
  logic [19:0] entry;

  // one write per step: shared setup, the range per link, then sync arm
  function automatic logic [19:0] slc_step(input logic [6:0] s);
    logic [6:0] k;
    logic pg;
    k = 7'(s - 7'd4);
    pg = k >= 7'(PER_LINK);
    if (pg) begin
      k = 7'(k - 7'(PER_LINK));
    end
    if (s == 7'd0) slc_step = {SAMPLE_FORMAT_CTRL_OFS, UNSIGNED_DATA, 7'h00};
    else if (s == 7'd1) slc_step = {INTERPOLATION_SELECT_OFS, INTERP};
    else if (s == 7'd2) slc_step = {LINK_POWER_CTRL_OFS, LINK_POWER_UP};
    else if (s == 7'd3) slc_step = {LANE_POWERDOWN_MASK_OFS, 8'(~((1 << LANES) - 1))};
    else if (s == 7'(LAST_STEP - 1)) slc_step = {SYNC_CTRL_OFS, SYNC_MODE_ONESHOT};
    else if (s == 7'(LAST_STEP)) slc_step = {SYNC_CTRL_OFS, SYNC_ARM};
    else begin
      unique case (k[3:0])
        4'h0: slc_step = {LINK_MODE_CTRL_OFS, 4'h0, TWO_LINKS, pg, 2'b00};
        4'h1: slc_step = {EXPECTED_DEVICE_IDENT_OFS, DEV_ID};
        4'h2: slc_step = {EXPECTED_BANK_IDENT_OFS, BANK_ID};
        4'h3: slc_step = {EXPECTED_LANE_IDENT_OFS, LANE_ID};
        4'h4: slc_step = {SCRAMBLE_LANE_COUNT_OFS, 3'h0, 5'(LANES - 1)};
        4'h5: slc_step = {OCTETS_PER_FRAME_OFS, 8'(OCTETS - 1)};
        4'h6: slc_step = {FRAMES_PER_MULTIFRAME_OFS, 8'(FRAMES - 1)};
        4'h7: slc_step = {CONVERTER_COUNT_OFS, 8'(CONVERTERS - 1)};
        4'h8: slc_step = {CONVERTER_RESOLUTION_OFS, 8'(RESOLUTION - 1)};
        4'h9: slc_step = {SUBCLASS_TOTAL_BITS_OFS, SUBCLASS_SEL, 5'(RESOLUTION - 1)};
        4'ha: slc_step = {VERSION_SAMPLES_OFS, REVISION, 5'(SAMPLES - 1)};
        4'hb: slc_step = {DENSITY_CONTROL_WORDS_OFS, 8'h00};
        4'hc: slc_step = {LANE_ZERO_CONFIG_SUM_OFS, 8'h00};
        4'hd: slc_step = {DESKEW_LANE_MASK_OFS, 8'((1 << LANES) - 1)};
        4'he: slc_step = {FRAME_OCTET_SETTING_OFS, 8'(OCTETS)};
        default: slc_step = {LANE_ENABLE_MASK_OFS, 8'((1 << LANES) - 1)};
      endcase
    end
  endfunction

  assign entry = slc_step(step_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SLC_IDLE;
      step_q <= '0;
      align_q <= '0;
    end else begin
      unique case (state_q)
        SLC_IDLE: begin
          step_q <= '0;
          align_q <= '0;
          if (start) begin
            state_q <= SLC_PROG;
          end
        end
        SLC_PROG: begin
          step_q <= 7'(step_q + 7'd1);
          if (step_q == 7'(LAST_STEP)) begin
            state_q <= SLC_ALIGN;
          end
        end
        SLC_ALIGN: begin
          align_q <= 2'(align_q + 2'd1);
          if (align_q == 2'd3) begin
            state_q <= SLC_RUN;
          end
        end
        SLC_RUN: ;
      endcase
    end
  end

  // align: cycle 0 sysref, cycle 1 link 0 config, 2 link 1, 3 mf start
  assign link.cfg_wr = state_q == SLC_PROG;
  assign link.cfg_rd = 1'b0;
  assign link.cfg_addr = entry[19:8];
  assign link.cfg_wdata = entry[7:0];
  assign link.sysref = state_q == SLC_ALIGN && align_q == 2'd0;
  assign link.ilas_valid = state_q == SLC_ALIGN &&
                           (align_q == 2'd1 || (align_q == 2'd2 && TWO_LINKS));
  assign link.ilas_link = align_q == 2'd2;
  assign link.ilas_did = DEV_ID;
  assign link.ilas_bid = BANK_ID;
  assign link.ilas_lid = LANE_ID;
  assign link.ilas_lane_m1 = 5'(LANES - 1);
  assign link.lane_mf_start = {NUM_LANES{state_q == SLC_ALIGN && align_q == 2'd3}};
  assign link.lane_octet = tx_octet;
  assign link.lane_valid = state_q == SLC_RUN && tx_valid;
  assign busy = state_q == SLC_PROG || state_q == SLC_ALIGN;
  assign ready = state_q == SLC_RUN;
endmodule

// [pkg/slc_link_if.sv]
// slc_link_if: register port plus lane-side signals between the
// configuration bank (cfg_dev) and the programming transmitter (cfg_host).
// assumes both ends run on the same clock; no timing lives here.
`timescale 1ns/1ps
interface slc_link_if #(parameter int NUM_LANES = 8);
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [NUM_LANES*8-1:0] lane_octet;
  logic lane_valid;
  logic [NUM_LANES-1:0] lane_mf_start;
  logic sysref;
  logic ilas_valid;
  logic ilas_link;
  logic [7:0] ilas_did;
  logic [7:0] ilas_bid;
  logic [7:0] ilas_lid;
  logic [4:0] ilas_lane_m1;

  modport dev (
    input cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
    output cfg_rdata, cfg_rvalid,
    input lane_octet, lane_valid, lane_mf_start, sysref,
    input ilas_valid, ilas_link, ilas_did, ilas_bid, ilas_lid, ilas_lane_m1
  );
  modport host (
    output cfg_addr, cfg_wdata, cfg_wr, cfg_rd,
    input cfg_rdata, cfg_rvalid,
    output lane_octet, lane_valid, lane_mf_start, sysref,
    output ilas_valid, ilas_link, ilas_did, ilas_bid, ilas_lid, ilas_lane_m1
  );
endinterface

// [pkg/slc_pkg.sv]
// slc_pkg: register map, field positions, reset values and limits for the
// link configuration bank and its programming end.
// assumes an 8-bit register port with 12-bit addresses and up to two links.
package slc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_LINKS = 2;
  localparam int BANK_REGS = 16;

  // shared registers
  localparam logic [11:0] SYNC_CTRL_OFS = 12'h03a;
  localparam logic [11:0] SAMPLE_FORMAT_CTRL_OFS = 12'h110;
  localparam logic [11:0] INTERPOLATION_SELECT_OFS = 12'h112;
  localparam logic [11:0] LINK_POWER_CTRL_OFS = 12'h200;
  localparam logic [11:0] LANE_POWERDOWN_MASK_OFS = 12'h201;
  // banked registers, one copy per link
  localparam logic [11:0] LINK_MODE_CTRL_OFS = 12'h300;
  localparam logic [11:0] EXPECTED_DEVICE_IDENT_OFS = 12'h450;
  localparam logic [11:0] EXPECTED_BANK_IDENT_OFS = 12'h451;
  localparam logic [11:0] EXPECTED_LANE_IDENT_OFS = 12'h452;
  localparam logic [11:0] SCRAMBLE_LANE_COUNT_OFS = 12'h453;
  localparam logic [11:0] OCTETS_PER_FRAME_OFS = 12'h454;
  localparam logic [11:0] FRAMES_PER_MULTIFRAME_OFS = 12'h455;
  localparam logic [11:0] CONVERTER_COUNT_OFS = 12'h456;
  localparam logic [11:0] CONVERTER_RESOLUTION_OFS = 12'h457;
  localparam logic [11:0] SUBCLASS_TOTAL_BITS_OFS = 12'h458;
  localparam logic [11:0] VERSION_SAMPLES_OFS = 12'h459;
  localparam logic [11:0] DENSITY_CONTROL_WORDS_OFS = 12'h45a;
  localparam logic [11:0] LANE_ZERO_CONFIG_SUM_OFS = 12'h45d;
  localparam logic [11:0] DESKEW_LANE_MASK_OFS = 12'h46c;
  localparam logic [11:0] FRAME_OCTET_SETTING_OFS = 12'h476;
  localparam logic [11:0] LANE_ENABLE_MASK_OFS = 12'h47d;

  // bank slot indices; all sixteen slots are in use, so a miss needs a fifth bit
  localparam logic [3:0] BK_MODE = 4'h0;
  localparam logic [3:0] BK_DID = 4'h1;
  localparam logic [3:0] BK_BID = 4'h2;
  localparam logic [3:0] BK_LID = 4'h3;
  localparam logic [3:0] BK_LANES = 4'h4;
  localparam logic [3:0] BK_SUBCLASS = 4'h9;
  localparam logic [3:0] BK_DESKEW = 4'hd;
  localparam logic [3:0] BK_LANE_EN = 4'hf;
  localparam logic [4:0] BK_NONE = 5'h10;

  // field positions
  localparam int SAMPLE_NUMBER_FORMAT_BIT = 7;
  localparam int CONFIG_SUM_METHOD_BIT = 6;
  localparam int TWO_LINK_ENABLE_BIT = 3;
  localparam int LINK_PAGE_SELECT_BIT = 2;
  localparam int SCRAMBLE_BIT = 7;
  localparam int LANE_COUNT_W = 5;
  localparam int SUBCLASS_LSB = 5;
  localparam int STANDARD_REVISION_LSB = 5;
  localparam int SYNC_ENABLE_BIT = 7;
  localparam int SYNC_ONESHOT_BIT = 0;

  // values
  localparam logic [7:0] LINK_POWER_RST = 8'hff;
  localparam logic [7:0] LINK_POWER_UP = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] SYNC_MODE_ONESHOT = 8'h01;
  localparam logic [7:0] SYNC_ARM = 8'h81;
  localparam logic [7:0] UNSIGNED_FLIP = 8'h80;

  // map an address to its bank slot, BK_NONE when not banked
  function automatic logic [4:0] slc_bank_index(input logic [11:0] a);
    unique case (a)
      LINK_MODE_CTRL_OFS: slc_bank_index = {1'b0, BK_MODE};
      EXPECTED_DEVICE_IDENT_OFS: slc_bank_index = {1'b0, BK_DID};
      EXPECTED_BANK_IDENT_OFS: slc_bank_index = {1'b0, BK_BID};
      EXPECTED_LANE_IDENT_OFS: slc_bank_index = {1'b0, BK_LID};
      SCRAMBLE_LANE_COUNT_OFS: slc_bank_index = {1'b0, BK_LANES};
      OCTETS_PER_FRAME_OFS: slc_bank_index = 5'h05;
      FRAMES_PER_MULTIFRAME_OFS: slc_bank_index = 5'h06;
      CONVERTER_COUNT_OFS: slc_bank_index = 5'h07;
      CONVERTER_RESOLUTION_OFS: slc_bank_index = 5'h08;
      SUBCLASS_TOTAL_BITS_OFS: slc_bank_index = {1'b0, BK_SUBCLASS};
      VERSION_SAMPLES_OFS: slc_bank_index = 5'h0a;
      DENSITY_CONTROL_WORDS_OFS: slc_bank_index = 5'h0b;
      LANE_ZERO_CONFIG_SUM_OFS: slc_bank_index = 5'h0c;
      DESKEW_LANE_MASK_OFS: slc_bank_index = {1'b0, BK_DESKEW};
      FRAME_OCTET_SETTING_OFS: slc_bank_index = 5'h0e;
      LANE_ENABLE_MASK_OFS: slc_bank_index = {1'b0, BK_LANE_EN};
      default: slc_bank_index = BK_NONE;
    endcase
  endfunction
endpackage
